// ### shared/cfips_regs.vh
// Purpose: Register map, field positions and codes of the CFI state block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Definitions only
`ifndef CFIPS_REGS_VH
`define CFIPS_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define CFIPS_CFG_OFS      8'h00
`define CFIPS_STATE_OFS    8'h04
`define CFIPS_ISTAT_OFS    8'h08
`define CFIPS_ICLR_OFS     8'h0C
`define CFIPS_IEN_OFS      8'h10
`define CFIPS_EFF_OFS      8'h14

// ==========================================================
// Config fields
`define CFIPS_CFG_MACHINE_LANDING_PAD_ENABLE     0
`define CFIPS_CFG_MENV_LPE 1
`define CFIPS_CFG_HENV_LPE 2
`define CFIPS_CFG_SENV_LPE 3
`define CFIPS_CFG_MENV_SSE 4
`define CFIPS_CFG_HENV_SSE 5
`define CFIPS_CFG_SENV_SSE 6
`define CFIPS_CFG_W        7
`define CFIPS_CFG_RST      7'h00

// ==========================================================
// State fields
`define CFIPS_ST_ELP       0
`define CFIPS_ST_MACHINE_PREV_LP_STATE     1
`define CFIPS_ST_SUPER_PREV_LP_STATE     2
`define CFIPS_ST_VSPELP    3
`define CFIPS_ST_DPELP     4

// ==========================================================
// Interrupt status fields
`define CFIPS_EV_LPFAULT   0
`define CFIPS_EV_SSPILL    1
`define CFIPS_EV_SSPVIRT   2
`define CFIPS_EV_W         3

// ==========================================================
// Privilege modes and trap targets
`define CFIPS_MODE_U       2'h0
`define CFIPS_MODE_S       2'h1
`define CFIPS_MODE_M       2'h3
`define CFIPS_TGT_M        2'h0
`define CFIPS_TGT_S        2'h1
`define CFIPS_TGT_VS       2'h2

// ==========================================================
// Exception codes and trap value
`define CFIPS_EXC_NONE     3'h0
`define CFIPS_EXC_ACCFLT   3'h1
`define CFIPS_EXC_SWCHK    3'h2
`define CFIPS_EXC_ILLEGAL  3'h3
`define CFIPS_EXC_VIRTINS  3'h4
`define CFIPS_LP_FAULT_TVAL 4'h2

// Expected landing pad encodings
`define CFIPS_LP_NOT_AWAITED 1'b0
`define CFIPS_LP_AWAITED     1'b1

`endif

// ### hdl/cfips_ctrl.v
// Purpose: CFI privilege state control of one hart
// Assumes: Hart-side inputs are on mclk; APB slave for config and state
// Notes:   All outputs registered; APB answers in the access cycle's 2nd edge
//
// Function
// - With S-mode, per-mode landing pad enable select
// - Without S-mode, M uses MACHINE_LANDING_PAD_ENABLE, U menv
// - Landing pad violation: software check, tval 2
// - Access fault above software check above illegal
// - Missing or faulting marker traps same-or-higher
// - Saved state bits for M, S, VS, debug
// - Trap: save state, then clear expected
// - Return: restore if new mode enabled, clear saved
// - Debug entry: save state, clear expected
// - Debug resume: restore if new mode enabled
// - Below M, menv shadow enable 0: illegal
// - Then U with senv shadow off: illegal
// - Then VS with henv shadow off: virtual
// - Then VU with either off: virtual, else allow
// - With S-mode, per-mode shadow enable select
// - Without S-mode, shadow enable always zero
// - Shadow disabled: shadow instructions act as fallback
// - Enable changes act immediately, no fence
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "cfips_regs.vh"

module cfips_ctrl #(
    parameter SMODE_PRESENT = 1
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Current hart mode
    input wire [1:0] privMode,
    input wire virtMode,
    // Instruction check request
    input wire insnValid,
    input wire insnIsLpad,
    input wire insnAccessFault,
    input wire insnIllegal,
    input wire lpadSelfFault,
    input wire indirectJump,
    input wire sspAccess,
    input wire ssInsn,
    // Trap, return and debug events
    input wire trapTake,
    input wire [1:0] trapTarget,
    input wire xretTake,
    input wire [1:0] xretSource,
    input wire [1:0] newMode,
    input wire newVirt,
    input wire debugEnter,
    input wire debugResume,
    // Results to hart
    output reg excValid,
    output reg [2:0] excCode,
    output reg [3:0] excTval,
    output reg lpEnableCur,
    output reg ssEnableCur,
    output reg ssFallback,
    output reg elpState,
    // Interrupt
    output reg irq
);

// ==========================================================
// Storage
reg [`CFIPS_CFG_W-1:0] cfg_r;
reg elp_r;
reg machine_prev_lp_state_r;
reg super_prev_lp_state_r;
reg vsPelp_r;
reg dPelp_r;
reg [`CFIPS_EV_W-1:0] iStat_r;
reg [`CFIPS_EV_W-1:0] iEn_r;

// ==========================================================
// Per-mode enable lookups
function lpeOf;
    input [1:0] mode;
    input virt;
    input [`CFIPS_CFG_W-1:0] c;
    begin
        if (mode == `CFIPS_MODE_M) begin
            lpeOf = c[`CFIPS_CFG_MACHINE_LANDING_PAD_ENABLE];
        end else if (SMODE_PRESENT == 0) begin
            lpeOf = c[`CFIPS_CFG_MENV_LPE];
        end else if (mode == `CFIPS_MODE_S && !virt) begin
            lpeOf = c[`CFIPS_CFG_MENV_LPE];
        end else if (mode == `CFIPS_MODE_S) begin
            lpeOf = c[`CFIPS_CFG_HENV_LPE];
        end else begin
            lpeOf = c[`CFIPS_CFG_SENV_LPE];
        end
    end
endfunction

function sseOf;
    input [1:0] mode;
    input virt;
    input [`CFIPS_CFG_W-1:0] c;
    begin
        if (SMODE_PRESENT == 0 || mode == `CFIPS_MODE_M) begin
            sseOf = 1'b0;
        end else if (mode == `CFIPS_MODE_S && !virt) begin
            sseOf = c[`CFIPS_CFG_MENV_SSE];
        end else if (mode == `CFIPS_MODE_S) begin
            sseOf = c[`CFIPS_CFG_HENV_SSE];
        end else begin
            sseOf = c[`CFIPS_CFG_SENV_SSE];
        end
    end
endfunction

// Combinational from live config, so a new enable applies next cycle
wire lpeNow = lpeOf(privMode, virtMode, cfg_r);
wire sseNow = sseOf(privMode, virtMode, cfg_r);
wire lpeNew = lpeOf(newMode, newVirt, cfg_r);

// ==========================================================
// Shadow stack pointer access check, ordered
reg [2:0] sspExc;
always @* begin
    sspExc = `CFIPS_EXC_NONE;
    if (privMode != `CFIPS_MODE_M && !cfg_r[`CFIPS_CFG_MENV_SSE]) begin
        sspExc = `CFIPS_EXC_ILLEGAL;
    end else if (privMode == `CFIPS_MODE_U && !virtMode &&
                 !cfg_r[`CFIPS_CFG_SENV_SSE]) begin
        sspExc = `CFIPS_EXC_ILLEGAL;
    end else if (privMode == `CFIPS_MODE_S && virtMode &&
                 !cfg_r[`CFIPS_CFG_HENV_SSE]) begin
        sspExc = `CFIPS_EXC_VIRTINS;
    end else if (privMode == `CFIPS_MODE_U && virtMode &&
                 !(cfg_r[`CFIPS_CFG_HENV_SSE] &&
                   cfg_r[`CFIPS_CFG_SENV_SSE])) begin
        sspExc = `CFIPS_EXC_VIRTINS;
    end
end

// ==========================================================
// Instruction exception selection
wire lpMissing = elp_r && !insnIsLpad;
wire lpFault = insnValid && (lpMissing || (insnIsLpad && lpadSelfFault));
reg [2:0] excSel;
reg [3:0] tvalSel;
always @* begin
    excSel = `CFIPS_EXC_NONE;
    tvalSel = 4'h0;
    if (insnValid && insnAccessFault) begin
        excSel = `CFIPS_EXC_ACCFLT;
    end else if (lpFault) begin
        excSel = `CFIPS_EXC_SWCHK;
        tvalSel = `CFIPS_LP_FAULT_TVAL;
    end else if (insnValid && insnIllegal) begin
        excSel = `CFIPS_EXC_ILLEGAL;
    end else if (insnValid && sspAccess) begin
        excSel = sspExc;
    end
end

// ==========================================================
// Expected landing pad state machine
reg elp_nxt;
reg machine_prev_lp_state_nxt;
reg super_prev_lp_state_nxt;
reg vsPelp_nxt;
reg dPelp_nxt;
wire apbWr = psel && penable && pready && pwrite;
wire apbRd = psel && penable && pready && !pwrite;
always @* begin
    elp_nxt = elp_r;
    machine_prev_lp_state_nxt = machine_prev_lp_state_r;
    super_prev_lp_state_nxt = super_prev_lp_state_r;
    vsPelp_nxt = vsPelp_r;
    dPelp_nxt = dPelp_r;
    // Handler save/restore path; hart events below override it
    if (apbWr && paddr == `CFIPS_STATE_OFS) begin
        machine_prev_lp_state_nxt = pwdata[`CFIPS_ST_MACHINE_PREV_LP_STATE];
        super_prev_lp_state_nxt = pwdata[`CFIPS_ST_SUPER_PREV_LP_STATE];
        vsPelp_nxt = pwdata[`CFIPS_ST_VSPELP];
        dPelp_nxt = pwdata[`CFIPS_ST_DPELP];
    end
    if (debugEnter) begin
        dPelp_nxt = elp_r;
        elp_nxt = `CFIPS_LP_NOT_AWAITED;
    end else if (trapTake) begin
        case (trapTarget)
            `CFIPS_TGT_M: machine_prev_lp_state_nxt = elp_r;
            `CFIPS_TGT_S: super_prev_lp_state_nxt = elp_r;
            `CFIPS_TGT_VS: vsPelp_nxt = elp_r;
            default: machine_prev_lp_state_nxt = elp_r;
        endcase
        elp_nxt = `CFIPS_LP_NOT_AWAITED;
    end else if (xretTake) begin
        case (xretSource)
            `CFIPS_TGT_M: begin
                elp_nxt = lpeNew ? machine_prev_lp_state_r : `CFIPS_LP_NOT_AWAITED;
                machine_prev_lp_state_nxt = `CFIPS_LP_NOT_AWAITED;
            end
            `CFIPS_TGT_S: begin
                elp_nxt = lpeNew ? super_prev_lp_state_r : `CFIPS_LP_NOT_AWAITED;
                super_prev_lp_state_nxt = `CFIPS_LP_NOT_AWAITED;
            end
            default: begin
                elp_nxt = lpeNew ? vsPelp_r : `CFIPS_LP_NOT_AWAITED;
                vsPelp_nxt = `CFIPS_LP_NOT_AWAITED;
            end
        endcase
    end else if (debugResume) begin
        elp_nxt = lpeNew ? dPelp_r : `CFIPS_LP_NOT_AWAITED;
    end else if (indirectJump && lpeNow) begin
        elp_nxt = `CFIPS_LP_AWAITED;
    end else if (insnValid && insnIsLpad && !lpFault &&
                 !insnAccessFault) begin
        elp_nxt = `CFIPS_LP_NOT_AWAITED;
    end
end

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        elp_r <= `CFIPS_LP_NOT_AWAITED;
        machine_prev_lp_state_r <= `CFIPS_LP_NOT_AWAITED;
        super_prev_lp_state_r <= `CFIPS_LP_NOT_AWAITED;
        vsPelp_r <= `CFIPS_LP_NOT_AWAITED;
        dPelp_r <= `CFIPS_LP_NOT_AWAITED;
    end else begin
        elp_r <= elp_nxt;
        machine_prev_lp_state_r <= machine_prev_lp_state_nxt;
        super_prev_lp_state_r <= super_prev_lp_state_nxt;
        vsPelp_r <= vsPelp_nxt;
        dPelp_r <= dPelp_nxt;
    end
end

// ==========================================================
// Sticky events; a new event beats a same-cycle clear
wire [`CFIPS_EV_W-1:0] evNow;
assign evNow[`CFIPS_EV_LPFAULT] = (excSel == `CFIPS_EXC_SWCHK);
assign evNow[`CFIPS_EV_SSPILL] = insnValid && sspAccess &&
    (excSel == `CFIPS_EXC_ILLEGAL) && !insnIllegal;
assign evNow[`CFIPS_EV_SSPVIRT] = (excSel == `CFIPS_EXC_VIRTINS);
wire clrHit = apbWr && paddr == `CFIPS_ICLR_OFS;

genvar gi;
generate
    for (gi = 0; gi < `CFIPS_EV_W; gi = gi + 1) begin : gEv
        always @(posedge mclk or posedge rst) begin
            if (rst) begin
                iStat_r[gi] <= 1'b0;
            end else if (evNow[gi]) begin
                iStat_r[gi] <= 1'b1;
            end else if (clrHit && pwdata[gi]) begin
                iStat_r[gi] <= 1'b0;
            end
        end
    end
endgenerate

// ==========================================================
// APB slave, one wait state
wire addrOk = (paddr == `CFIPS_CFG_OFS) || (paddr == `CFIPS_STATE_OFS) ||
    (paddr == `CFIPS_ISTAT_OFS) || (paddr == `CFIPS_ICLR_OFS) ||
    (paddr == `CFIPS_IEN_OFS) || (paddr == `CFIPS_EFF_OFS);
reg [31:0] rdMux;
always @* begin
    rdMux = 32'h00000000;
    case (paddr)
        `CFIPS_CFG_OFS: rdMux[`CFIPS_CFG_W-1:0] = cfg_r;
        `CFIPS_STATE_OFS: rdMux[4:0] =
            {dPelp_r, vsPelp_r, super_prev_lp_state_r, machine_prev_lp_state_r, elp_r};
        `CFIPS_ISTAT_OFS: rdMux[`CFIPS_EV_W-1:0] = iStat_r;
        `CFIPS_IEN_OFS: rdMux[`CFIPS_EV_W-1:0] = iEn_r;
        `CFIPS_EFF_OFS: rdMux[1:0] = {sseNow, lpeNow};
        default: rdMux = 32'h00000000;
    endcase
end

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        cfg_r <= `CFIPS_CFG_RST;
        iEn_r <= {`CFIPS_EV_W{1'b0}};
    end else begin
        pready <= psel && penable && !pready;
        pslverr <= psel && penable && !pready && !addrOk;
        if (psel && penable && !pready && !pwrite) begin
            prdata <= rdMux;
        end else if (apbRd) begin
            prdata <= prdata;
        end else begin
            prdata <= 32'h00000000;
        end
        if (apbWr && paddr == `CFIPS_CFG_OFS) begin
            cfg_r <= pwdata[`CFIPS_CFG_W-1:0];
        end
        if (apbWr && paddr == `CFIPS_IEN_OFS) begin
            iEn_r <= pwdata[`CFIPS_EV_W-1:0];
        end
    end
end

// ==========================================================
// Registered results to the hart
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        excValid <= 1'b0;
        excCode <= `CFIPS_EXC_NONE;
        excTval <= 4'h0;
        lpEnableCur <= 1'b0;
        ssEnableCur <= 1'b0;
        ssFallback <= 1'b0;
        elpState <= `CFIPS_LP_NOT_AWAITED;
        irq <= 1'b0;
    end else begin
        excValid <= (excSel != `CFIPS_EXC_NONE);
        excCode <= excSel;
        excTval <= tvalSel;
        lpEnableCur <= lpeNow;
        ssEnableCur <= sseNow;
        ssFallback <= insnValid && ssInsn && !sseNow;
        elpState <= elp_nxt;
        irq <= |((iStat_r | evNow) & iEn_r);
    end
end

endmodule // cfips_ctrl

// ### verification/cfips_ctrl_props.sv
// Purpose: Port assertions for cfips_ctrl
// Assumes: Config bits are internal, so checks key on outputs
// Notes:   Bound into every cfips_ctrl instance
`timescale 1ns/10ps
`include "cfips_regs.vh"

module cfips_ctrl_props (
    // Clock, reset, APB
    input wire mclk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    // Hart side
    input wire [1:0] privMode,
    input wire insnValid,
    input wire insnIsLpad,
    input wire insnAccessFault,
    input wire insnIllegal,
    input wire lpadSelfFault,
    input wire sspAccess,
    input wire ssInsn,
    input wire trapTake,
    input wire debugEnter,
    input wire excValid,
    input wire [2:0] excCode,
    input wire [3:0] excTval,
    input wire ssEnableCur,
    input wire ssFallback,
    input wire elpState,
    input wire irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // ======
    // Sequences
    sequence apbWait;
        psel && penable && !pready;
    endsequence
    sequence lpMissed;
        insnValid && elpState && !insnIsLpad && !insnAccessFault;
    endsequence

    // ======
    // Assertions
    AST_APB_ONE_WAIT: assert property (apbWait |=> pready ##1 !pready)
        else $error("pready not after one wait state");
    AST_APB_UNMAPPED: assert property (apbWait ##0 paddr > 8'h14 |=> pslverr)
        else $error("unmapped access without slave error");
    AST_LP_FAULT: assert property (lpMissed |=> excValid &&
        excCode == `CFIPS_EXC_SWCHK && excTval == `CFIPS_LP_FAULT_TVAL)
        else $error("missing landing pad not reported");
    AST_ACC_FIRST: assert property (insnValid && insnAccessFault
        |=> excCode == `CFIPS_EXC_ACCFLT) else $error("access fault lost");
    AST_ILL_PLAIN: assert property (insnValid && !elpState &&
        insnIllegal && !insnAccessFault && !lpadSelfFault
        |=> excCode == `CFIPS_EXC_ILLEGAL)
        else $error("illegal instruction lost");
    AST_TRAP_CLEAR: assert property (trapTake |=> !elpState)
        else $error("expected state kept over trap");
    AST_DEBUG_CLEAR: assert property (debugEnter |=> !elpState)
        else $error("expected state kept over debug entry");
    AST_SS_M_OFF: assert property (privMode == `CFIPS_MODE_M
        |=> !ssEnableCur) else $error("shadow enable set in machine mode");
    AST_SS_FALLBACK: assert property (insnValid && ssInsn &&
        privMode == `CFIPS_MODE_M |=> ssFallback)
        else $error("shadow instruction not in fallback");
    AST_SSP_M_FREE: assert property (insnValid && sspAccess &&
        privMode == `CFIPS_MODE_M && !elpState && !insnAccessFault &&
        !insnIllegal && !lpadSelfFault |=> excCode == `CFIPS_EXC_NONE)
        else $error("machine mode pointer access refused");
    // Sticky status: irq only drops after a register write
    AST_IRQ_STICKY: assert property ($fell(irq) |->
        $past(pwrite && pready) || $past(pwrite && pready, 2))
        else $error("irq dropped without a write");
endmodule // cfips_ctrl_props

bind cfips_ctrl cfips_ctrl_props i_cfips_ctrl_props (.*);

// ### verification/tb.sv
// Purpose: Self-checking bench for cfips_ctrl
// Assumes: APB with one wait state, hart results one cycle late
// Notes:   Config and modes drawn from a fixed-seed LFSR
`timescale 1ns/10ps
`include "cfips_regs.vh"

module tb;
    // ======
    // Signals
    reg mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    reg virtMode = 0, newVirt = 0, lpadSelfFault = 0, v;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rd, seed = 32'hBCE131CF;
    reg [1:0] privMode = 2'h3, trapTarget = 2'h0, xretSource = 2'h0;
    reg [1:0] newMode = 2'h0, m;
    reg [5:0] evts = 6'h00;
    reg [4:0] qual = 5'h00;
    reg [6:0] cfg;
    integer badCount = 0, checksDone = 0, cyc = 0, i;
    wire insnValid = evts[5], indirectJump = evts[4], trapTake = evts[3];
    wire xretTake = evts[2], debugEnter = evts[1], debugResume = evts[0];
    wire insnIsLpad = qual[4], insnAccessFault = qual[3];
    wire insnIllegal = qual[2], sspAccess = qual[1], ssInsn = qual[0];
    wire [31:0] prdata;
    wire [2:0] excCode;
    wire [3:0] excTval;
    wire pready, pslverr, excValid, lpEnableCur, ssEnableCur, ssFallback;
    wire elpState, irq;

    cfips_ctrl i_cfips_ctrl (.*);

    initial forever #2.5 mclk = ~mclk;

    // ======
    // Expectations
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function landing_pad_enable(input [6:0] c, input [1:0] md, input vt);
        landing_pad_enable = (md == 2'h3) ? c[0] : (md == 2'h1) ? (vt ? c[2] : c[1]) : c[3];
    endfunction
    function shadow_stack_enable(input [6:0] c, input [1:0] md, input vt);
        shadow_stack_enable = (md == 2'h3) ? 1'b0 : (md == 2'h1) ? (vt ? c[5] : c[4]) : c[6];
    endfunction
    function [2:0] sspCode(input [6:0] c, input [1:0] md, input vt);
        if (md != 2'h3 && !c[4])
            sspCode = `CFIPS_EXC_ILLEGAL;
        else if (md == 2'h0 && !vt && !c[6])
            sspCode = `CFIPS_EXC_ILLEGAL;
        else if (vt && (!c[5] || (md == 2'h0 && !c[6])))
            sspCode = `CFIPS_EXC_VIRTINS;
        else
            sspCode = `CFIPS_EXC_NONE;
    endfunction

    // ======
    // Tasks
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checksDone = checksDone + 1;
            if (got !== exp) begin
                badCount = badCount + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1;
            @(posedge mclk);
            // pready ends this wait; the bench timeout ends a hang
            while (!pready) begin
                @(posedge mclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    // One-cycle hart pulse, then look once outputs settle
    task ev(input [5:0] e, input [4:0] q);
        begin
            @(posedge mclk);
            evts <= e;
            qual <= q;
            @(posedge mclk);
            evts <= 6'h00;
            #1;
        end
    endtask
    task completeRun;
        begin
            $display("checks %0d mismatches %0d", checksDone, badCount);
            if (badCount == 0 && checksDone > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            badCount = badCount + 1;
            completeRun;
        end
    end

    // ======
    // Sequence
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 0;
        apb(0, `CFIPS_STATE_OFS, 0);
        chk(rd, 0);
        apb(0, 8'h40, 0);
        chk(err, 1);
        $display("reset test done");
        for (i = 0; i < 24; i = i + 1) begin
            seed = lfsr(seed);
            cfg = seed[6:0];
            m = (seed[9:8] == 2'h2) ? 2'h3 : seed[9:8];
            v = seed[10] && m != 2'h3;
            apb(1, `CFIPS_CFG_OFS, {25'h0, cfg});
            privMode <= m;
            virtMode <= v;
            ev(6'h20, 5'h03);
            chk(excCode, sspCode(cfg, m, v));
            chk(ssFallback, !shadow_stack_enable(cfg, m, v));
            // Extra cycle: enables lag the mode by one
            ev(0, 0);
            chk(lpEnableCur, landing_pad_enable(cfg, m, v));
            chk(ssEnableCur, shadow_stack_enable(cfg, m, v));
            apb(0, `CFIPS_EFF_OFS, 0);
            chk(rd, {shadow_stack_enable(cfg, m, v), landing_pad_enable(cfg, m, v)});
        end
        $display("enable test done");
        apb(1, `CFIPS_CFG_OFS, 32'h7F);
        privMode <= 2'h3;
        virtMode <= 0;
        apb(1, `CFIPS_ICLR_OFS, 32'h7);
        apb(1, `CFIPS_IEN_OFS, 32'h1);
        ev(6'h10, 0);
        chk(elpState, 1);
        ev(6'h20, 5'h04);
        chk({excValid, excCode, excTval}, 8'hA2);
        chk(irq, 1);
        ev(6'h20, 5'h0C);
        chk(excCode, `CFIPS_EXC_ACCFLT);
        trapTarget <= `CFIPS_TGT_M;
        ev(6'h08, 0);
        apb(0, `CFIPS_STATE_OFS, 0);
        chk(rd, 32'h2);
        ev(6'h20, 5'h04);
        chk(excCode, `CFIPS_EXC_ILLEGAL);
        newMode <= 2'h3;
        ev(6'h04, 0);
        apb(0, `CFIPS_STATE_OFS, 0);
        chk(rd, 32'h1);
        lpadSelfFault <= 1;
        ev(6'h20, 5'h10);
        chk(excCode, `CFIPS_EXC_SWCHK);
        lpadSelfFault <= 0;
        apb(1, `CFIPS_CFG_OFS, 32'h77);
        trapTarget <= `CFIPS_TGT_S;
        ev(6'h08, 0);
        apb(0, `CFIPS_STATE_OFS, 0);
        chk(rd, 32'h4);
        xretSource <= 2'h1;
        newMode <= 2'h0;
        ev(6'h04, 0);
        apb(0, `CFIPS_STATE_OFS, 0);
        chk(rd, 0);
        ev(6'h10, 0);
        ev(6'h02, 0);
        apb(0, `CFIPS_STATE_OFS, 0);
        chk(rd, 32'h10);
        newMode <= 2'h1;
        newVirt <= 1;
        ev(6'h01, 0);
        chk(elpState, 1);
        apb(0, `CFIPS_ISTAT_OFS, 0);
        chk(rd, 32'h1);
        $display("landing pad test done");
        apb(1, `CFIPS_IEN_OFS, 0);
        ev(0, 0);
        chk(irq, 0);
        apb(1, `CFIPS_IEN_OFS, 1);
        ev(0, 0);
        chk(irq, 1);
        apb(1, `CFIPS_ICLR_OFS, 1);
        ev(0, 0);
        chk(irq, 0);
        $display("interrupt test done");
        completeRun;
    end
endmodule // tb
